//--- common/boundary_run_test_consts.vh
// Constants shared by the boundary run-test engine files
`ifndef BOUNDARY_RUN_TEST_CONSTS_VH
`define BOUNDARY_RUN_TEST_CONSTS_VH

// Control register layout
`define CTRL_W 11
`define CTRL_RST 11'h000
`define OPC_MSB 2
`define OPC_LSB 0
`define OPC_LOW_MSB 1
`define MASK_MSB 10
`define MASK_LSB 3

// Operation codes, low two bits where the top bit is ignored, except 011 and 111 which use all three bits
`define CODE_SAMPLE 2'h0
`define CODE_PATTERN 2'h1
`define CODE_SIGNATURE 2'h2
`define CODE_SIG_PATTERN 3'h3
`define CODE_SIG_COUNT 3'h7

// Cell groups: each pin side has an input and an output cell group
`define GRP_W 8
`define GRP_RST 8'h00
`define GRP_A_IN 2'h0
`define GRP_A_OUT 2'h1
`define GRP_B_IN 2'h2
`define GRP_B_OUT 2'h3
`define GRP_CNT 4

// Galois feedback masks for maximal-length polynomials
`define TAPS_16 16'hb400
`define TAPS_8 8'hb8
`define ONE_8 8'h01

`endif

//--- logic/sync_2ff.v
// Two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps

module sync_2ff #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);

reg [WIDTH-1:0] meta_r;

// First stage feeds only the second stage
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        meta_r <= {WIDTH{1'b0}};
        dout <= {WIDTH{1'b0}};
    end
    else
    begin
        meta_r <= din;
        dout <= meta_r;
    end
end

endmodule

//--- logic/lfsr_next.v
// One step of a Galois linear-feedback register with parallel data folded in
`timescale 1ns/1ps
`include "boundary_run_test_consts.vh"

module lfsr_next #(
    parameter WIDTH = 16,
    parameter [WIDTH-1:0] TAPS = `TAPS_16
) (
    input wire [WIDTH-1:0] state,
    input wire [WIDTH-1:0] data,
    output wire [WIDTH-1:0] next
);

// Shift right, feed back the low bit through the taps, then mix data in.
// With zero data an all-zero state stays all zero.
assign next = (state >> 1) ^ (state[0] ? TAPS : {WIDTH{1'b0}}) ^ data;

endmodule

//--- logic/boundary_run_test_engine.v
// Boundary run-test engine: sample/toggle, pattern, signature and count modes
`timescale 1ns/1ps
`include "boundary_run_test_consts.vh"

// What this block does
// - Operation picked from the three low bits of the control register.
// - X00 sample/toggle, X01 16-bit pattern, X10 16-bit signature.
// - 011 8-bit signature plus pattern; 111 8-bit signature plus count.
// - Operations run only under the run-test instruction in Run-Test/Idle.
// - Control-input cells, chain bits 39 to 32, stay out of all algorithms.
// - Output-enable cells still decide whether output pins drive.
// - Operations run only when the two direction enables differ, else bypass.
// - Control bits 10 to 3 mask inputs 8 to 1 on the input side.
// - A masked input does not affect the signature; unmasked ones compress.
// - Sample mode captures input pins each TCK rise and feeds the core.
// - Toggle inverts output cells each rise, drives pins each fall.
// - Pattern mode steps a 16-bit LFSR each rise, applies it each fall.
// - An all-zero seed keeps the pattern stuck at zero.
// - Signature mode compresses unmasked inputs into 16 bits each rise.
// - In 16-bit signature mode output latches hold and keep driving.
// - Combined 8-bit mode compresses unmasked inputs into 8 bits each rise.
// - Code 011 also steps an 8-bit pattern in the output cells.
// - Count mode counts up; opposite output cells take carries, 16 bits.
module boundary_run_test_engine #(
    parameter CW = `CTRL_W,
    parameter GW = `GRP_W
) (
    input wire SYS_CLK,
    input wire SYS_RST,
    input wire TCK,
    input wire RUN_TEST_IDLE,
    input wire A_OE_CELL_N,
    input wire B_OE_CELL_N,
    input wire CTRL_UPDATE,
    input wire [CW-1:0] CTRL_IN,
    input wire SEED_LOAD,
    input wire [4*GW-1:0] SEED_IN,
    input wire [GW-1:0] A_PIN_IN,
    input wire [GW-1:0] B_PIN_IN,
    output reg [GW-1:0] A_PIN_OUT,
    output reg A_PIN_OE,
    output reg [GW-1:0] B_PIN_OUT,
    output reg B_PIN_OE,
    output reg [GW-1:0] CORE_A_IN,
    output reg [GW-1:0] CORE_B_IN,
    output reg [CW-1:0] CTRL_STATE,
    output reg [4*GW-1:0] CELL_STATE,
    output reg [5:0] MODE_STATE
);

// One-hot operation states
localparam [5:0] ST_IDLE = 6'h01;
localparam [5:0] ST_SAMPLE = 6'h02;
localparam [5:0] ST_PATTERN = 6'h04;
localparam [5:0] ST_SIGNATURE = 6'h08;
localparam [5:0] ST_SIG_PATTERN = 6'h10;
localparam [5:0] ST_SIG_COUNT = 6'h20;

localparam SW = 6 + CW + 4 * GW + 2 * GW;

// Map the low control bits onto an operation state
function [5:0] decode_op;
    input [`OPC_MSB:`OPC_LSB] code;
    begin
        if (code == `CODE_SIG_PATTERN)
            decode_op = ST_SIG_PATTERN;
        else if (code == `CODE_SIG_COUNT)
            decode_op = ST_SIG_COUNT;
        else
        begin
            case (code[`OPC_LOW_MSB:`OPC_LSB])
                `CODE_SAMPLE: decode_op = ST_SAMPLE;
                `CODE_PATTERN: decode_op = ST_PATTERN;
                `CODE_SIGNATURE: decode_op = ST_SIGNATURE;
                default: decode_op = ST_IDLE;
            endcase
        end
    end
endfunction

// Everything from the TAP side and the pins is asynchronous to SYS_CLK.
// Buses are only read on a synchronised strobe edge or on a TCK edge,
// which lags them by the same two stages, so bit skew does not matter.
wire [SW-1:0] raw_in;
wire [SW-1:0] syn;

assign raw_in = {TCK, RUN_TEST_IDLE, A_OE_CELL_N, B_OE_CELL_N, CTRL_UPDATE,
    SEED_LOAD, CTRL_IN, SEED_IN, A_PIN_IN, B_PIN_IN};

sync_2ff #(
    .WIDTH(SW)
) u_sync (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .din(raw_in),
    .dout(syn)
);

wire s_tck = syn[SW-1];
wire s_run = syn[SW-2];
wire s_oea_n = syn[SW-3];
wire s_oeb_n = syn[SW-4];
wire s_upd = syn[SW-5];
wire s_seed = syn[SW-6];
wire [CW-1:0] s_ctrl = syn[4*GW+2*GW+CW-1:4*GW+2*GW];
wire [4*GW-1:0] s_seed_val = syn[4*GW+2*GW-1:2*GW];
wire [GW-1:0] s_a_pin = syn[2*GW-1:GW];
wire [GW-1:0] s_b_pin = syn[GW-1:0];

reg tck_d_r;
reg upd_d_r;
reg seed_d_r;
reg [CW-1:0] ctrl_r;
reg [5:0] mode_r;
reg [5:0] mode_nxt;
reg [GW-1:0] sh_r [0:`GRP_CNT-1];
reg [GW-1:0] lat_r [0:`GRP_CNT-1];
integer i;

// Edges of the sampled TCK and of the TAP strobes
wire tck_rise = s_tck & ~tck_d_r;
wire tck_fall = ~s_tck & tck_d_r;
wire upd_rise = s_upd & ~upd_d_r;
wire seed_rise = s_seed & ~seed_d_r;

// Exactly one direction enabled; A_OE_CELL_N high means A-to-B flow
wire dir_ok = s_oea_n ^ s_oeb_n;
wire a_to_b = s_oea_n;
wire [1:0] g_in = a_to_b ? `GRP_A_IN : `GRP_B_IN;
wire [1:0] g_out = a_to_b ? `GRP_B_OUT : `GRP_A_OUT;
wire [1:0] g_opp = a_to_b ? `GRP_A_OUT : `GRP_B_OUT;
wire [GW-1:0] pins_in = a_to_b ? s_a_pin : s_b_pin;

// Only the selected data cells are wired in; control cells never are
wire [GW-1:0] in_sh = sh_r[g_in];
wire [GW-1:0] out_sh = sh_r[g_out];
wire [GW-1:0] opp_sh = sh_r[g_opp];

// Bit 10 masks input 8 down to bit 3 masking input 1
wire [GW-1:0] mask = ctrl_r[`MASK_MSB:`MASK_LSB];
wire [GW-1:0] din_m = pins_in & ~mask;

// Mode selection follows the synchronised run-test qualifier
always @*
begin
    if (s_run && dir_ok)
        mode_nxt = decode_op(ctrl_r[`OPC_MSB:`OPC_LSB]);
    else
        mode_nxt = ST_IDLE;
end

// Feedback steps; output cells form the upper half of the 16-bit register
wire [2*GW-1:0] st16 = {out_sh, in_sh};
wire [2*GW-1:0] dat16 = (mode_r == ST_SIGNATURE) ? {{GW{1'b0}}, din_m} : {2*GW{1'b0}};
wire [2*GW-1:0] nxt16;
wire [GW-1:0] nxt8_sig;
wire [GW-1:0] nxt8_pat;
wire [GW:0] cnt_sum = {1'b0, out_sh} + {1'b0, `ONE_8};

lfsr_next #(
    .WIDTH(2 * GW),
    .TAPS(`TAPS_16)
) u_lfsr16 (
    .state(st16),
    .data(dat16),
    .next(nxt16)
);

lfsr_next #(
    .WIDTH(GW),
    .TAPS(`TAPS_8)
) u_sig8 (
    .state(in_sh),
    .data(din_m),
    .next(nxt8_sig)
);

lfsr_next #(
    .WIDTH(GW),
    .TAPS(`TAPS_8)
) u_pat8 (
    .state(out_sh),
    .data({GW{1'b0}}),
    .next(nxt8_pat)
);

// Strobe history, control register and operation state
always @(posedge SYS_CLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        tck_d_r <= 1'b0;
        upd_d_r <= 1'b0;
        seed_d_r <= 1'b0;
        ctrl_r <= `CTRL_RST;
        mode_r <= ST_IDLE;
    end
    else
    begin
        tck_d_r <= s_tck;
        upd_d_r <= s_upd;
        seed_d_r <= s_seed;
        if (upd_rise)
            ctrl_r <= s_ctrl;
        mode_r <= mode_nxt;
    end
end

// Shift stages change on TCK rise, shadow latches on TCK fall.
// A seed scan is only honoured while no operation runs, so a stray
// strobe cannot corrupt a signature being gathered.
always @(posedge SYS_CLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        for (i = 0; i < `GRP_CNT; i = i + 1)
        begin
            sh_r[i] <= `GRP_RST;
            lat_r[i] <= `GRP_RST;
        end
    end
    else if (mode_r == ST_IDLE)
    begin
        if (seed_rise)
        begin
            for (i = 0; i < `GRP_CNT; i = i + 1)
                sh_r[i] <= s_seed_val[i*GW +: GW];
        end
    end
    else if (tck_rise)
    begin
        case (mode_r)
            ST_SAMPLE:
            begin
                sh_r[g_in] <= pins_in;
                sh_r[g_out] <= ~out_sh;
            end
            ST_PATTERN, ST_SIGNATURE:
            begin
                sh_r[g_out] <= nxt16[2*GW-1:GW];
                sh_r[g_in] <= nxt16[GW-1:0];
            end
            ST_SIG_PATTERN:
            begin
                sh_r[g_in] <= nxt8_sig;
                sh_r[g_out] <= nxt8_pat;
            end
            ST_SIG_COUNT:
            begin
                sh_r[g_in] <= nxt8_sig;
                sh_r[g_out] <= cnt_sum[GW-1:0];
                sh_r[g_opp] <= opp_sh + {{(GW-1){1'b0}}, cnt_sum[GW]};
            end
            default:
            begin
                sh_r[g_in] <= in_sh;
            end
        endcase
    end
    else if (tck_fall)
    begin
        lat_r[g_in] <= in_sh;
        if (mode_r != ST_SIGNATURE)
            lat_r[g_out] <= out_sh;
        else
            lat_r[g_out] <= lat_r[g_out];
    end
end

// Output stage: pins and core inputs follow the shadow latches
always @(posedge SYS_CLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        A_PIN_OUT <= `GRP_RST;
        B_PIN_OUT <= `GRP_RST;
        A_PIN_OE <= 1'b0;
        B_PIN_OE <= 1'b0;
        CORE_A_IN <= `GRP_RST;
        CORE_B_IN <= `GRP_RST;
        CTRL_STATE <= `CTRL_RST;
        CELL_STATE <= {4*GW{1'b0}};
        MODE_STATE <= ST_IDLE;
    end
    else
    begin
        A_PIN_OUT <= lat_r[`GRP_A_OUT];
        B_PIN_OUT <= lat_r[`GRP_B_OUT];
        A_PIN_OE <= ~s_oea_n;
        B_PIN_OE <= ~s_oeb_n;
        CORE_A_IN <= lat_r[`GRP_A_IN];
        CORE_B_IN <= lat_r[`GRP_B_IN];
        CTRL_STATE <= ctrl_r;
        CELL_STATE <= {sh_r[3], sh_r[2], sh_r[1], sh_r[0]};
        MODE_STATE <= mode_r;
    end
end

endmodule

//--- testbench/tck_source_model.sv
// Test controller model: bursts of TCK while the TAP rests in Run-Test/Idle
`timescale 1ns/1ps
module tck_source_model #(
    parameter N = 3
) (
    input wire logic clk,
    input wire logic go,
    output logic tck,
    output logic busy
);
    logic [5:0] cnt_r = 6'h00;
    wire [5:0] ph = cnt_r - 6'h01;
    assign busy = cnt_r != 6'h00;
    // TCK stands low between bursts, like a real controller parked in idle
    assign tck = busy & ph[2];
    // Eight system clocks give one 200 ns test clock period
    always @(negedge clk)
        if (go && !busy)
            cnt_r <= 6'(N * 8);
        else if (busy)
            cnt_r <= ph;
endmodule

//--- testbench/boundary_run_test_asserts.sv
// Port-level checks for the boundary run-test engine
`timescale 1ns/1ps
module boundary_run_test_asserts #(
    parameter CW = 11,
    parameter GW = 8
) (
    input wire SYS_CLK,
    input wire SYS_RST,
    input wire TCK,
    input wire RUN_TEST_IDLE,
    input wire A_OE_CELL_N,
    input wire B_OE_CELL_N,
    input wire SEED_LOAD,
    input wire [CW-1:0] CTRL_IN,
    input wire [GW-1:0] A_PIN_OUT,
    input wire A_PIN_OE,
    input wire [GW-1:0] B_PIN_OUT,
    input wire B_PIN_OE,
    input wire [GW-1:0] CORE_A_IN,
    input wire [CW-1:0] CTRL_STATE,
    input wire [4*GW-1:0] CELL_STATE,
    input wire [5:0] MODE_STATE
);
    reg [2:0] settle_r;
    wire [2:0] settle_nxt = settle_r + {2'h0, settle_r != 3'h7};
    wire settled = settle_r == 3'h7;
    // Enables lag reset release by the synchronisers
    always @(posedge SYS_CLK or posedge SYS_RST)
        if (SYS_RST)
            settle_r <= 3'h0;
        else
            settle_r <= settle_nxt;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);

    function automatic [5:0] dec(input [2:0] c);
        dec = c == 3'h3 ? 6'h10 : c == 3'h7 ? 6'h20 : 6'h02 << c[1:0];
    endfunction

    // Six quiet cycles, five for the enables, let async inputs cross the synchronisers
    sequence run_held;
        (RUN_TEST_IDLE && A_OE_CELL_N != B_OE_CELL_N && $stable(CTRL_STATE)) [*6];
    endsequence
    sequence stop_held;
        (!RUN_TEST_IDLE || A_OE_CELL_N == B_OE_CELL_N) [*6];
    endsequence
    sequence oe_held;
        (settled && $stable(A_OE_CELL_N) && $stable(B_OE_CELL_N)) [*5];
    endsequence

    mode_onehot_a: assert property ($onehot(MODE_STATE))
        else $error("mode state not one-hot");
    mode_decode_a: assert property (run_held |-> MODE_STATE == dec(CTRL_STATE[2:0]))
        else $error("mode does not match control code");
    mode_bypass_a: assert property (stop_held |-> MODE_STATE == 6'h01)
        else $error("operation runs outside run-test");
    ctrl_load_a: assert property ($changed(CTRL_STATE) |-> CTRL_STATE == CTRL_IN)
        else $error("control register took a wrong value");
    idle_hold_a: assert property ((MODE_STATE == 6'h01 && !SEED_LOAD) [*6]
        |-> $stable(CELL_STATE)) else $error("cells moved while idle");
    sig_hold_a: assert property (MODE_STATE == 6'h08 [*2]
        |-> $stable(A_PIN_OUT) && $stable(B_PIN_OUT)) else $error("latch moved in signature");
    latch_quiet_a: assert property ($stable(TCK) [*8]
        |-> $stable({A_PIN_OUT, B_PIN_OUT, CORE_A_IN})) else $error("latch moved without TCK");
    oe_track_a: assert property (oe_held
        |-> A_PIN_OE == !A_OE_CELL_N && B_PIN_OE == !B_OE_CELL_N) else $error("enable mismatch");
endmodule

bind boundary_run_test_engine boundary_run_test_asserts #(
    .CW(CW),
    .GW(GW)
) chk (
    .SYS_CLK(SYS_CLK),
    .SYS_RST(SYS_RST),
    .TCK(TCK),
    .RUN_TEST_IDLE(RUN_TEST_IDLE),
    .A_OE_CELL_N(A_OE_CELL_N),
    .B_OE_CELL_N(B_OE_CELL_N),
    .SEED_LOAD(SEED_LOAD),
    .CTRL_IN(CTRL_IN),
    .A_PIN_OUT(A_PIN_OUT),
    .A_PIN_OE(A_PIN_OE),
    .B_PIN_OUT(B_PIN_OUT),
    .B_PIN_OE(B_PIN_OE),
    .CORE_A_IN(CORE_A_IN),
    .CTRL_STATE(CTRL_STATE),
    .CELL_STATE(CELL_STATE),
    .MODE_STATE(MODE_STATE)
);

//--- testbench/test_boundary_run_test_engine.sv
// Self-checking bench for the boundary run-test engine
`timescale 1ns/1ps
`include "boundary_run_test_consts.vh"
module test_boundary_run_test_engine;
    logic SYS_CLK, SYS_RST = 1, RUN_TEST_IDLE = 0, A_OE_CELL_N = 1, B_OE_CELL_N = 0;
    logic CTRL_UPDATE = 0, SEED_LOAD = 0, go = 0;
    logic [10:0] CTRL_IN = 11'h000;
    logic [31:0] SEED_IN = 32'h00000000;
    logic [7:0] A_PIN_IN = 8'h00, B_PIN_IN = 8'h00;
    wire TCK, busy, A_PIN_OE, B_PIN_OE;
    wire [7:0] A_PIN_OUT, B_PIN_OUT, CORE_A_IN, CORE_B_IN;
    wire [10:0] CTRL_STATE;
    wire [31:0] CELL_STATE;
    wire [5:0] MODE_STATE;
    int failures = 0, check_count = 0;

    boundary_run_test_engine DUT (
        .SYS_CLK(SYS_CLK),
        .SYS_RST(SYS_RST),
        .TCK(TCK),
        .RUN_TEST_IDLE(RUN_TEST_IDLE),
        .A_OE_CELL_N(A_OE_CELL_N),
        .B_OE_CELL_N(B_OE_CELL_N),
        .CTRL_UPDATE(CTRL_UPDATE),
        .CTRL_IN(CTRL_IN),
        .SEED_LOAD(SEED_LOAD),
        .SEED_IN(SEED_IN),
        .A_PIN_IN(A_PIN_IN),
        .B_PIN_IN(B_PIN_IN),
        .A_PIN_OUT(A_PIN_OUT),
        .A_PIN_OE(A_PIN_OE),
        .B_PIN_OUT(B_PIN_OUT),
        .B_PIN_OE(B_PIN_OE),
        .CORE_A_IN(CORE_A_IN),
        .CORE_B_IN(CORE_B_IN),
        .CTRL_STATE(CTRL_STATE),
        .CELL_STATE(CELL_STATE),
        .MODE_STATE(MODE_STATE)
    );
    tck_source_model tck_src (.clk(SYS_CLK), .go(go), .tck(TCK), .busy(busy));

    function automatic logic [15:0] g16(input logic [15:0] s, input logic [15:0] x);
        return (s >> 1) ^ (s[0] ? `TAPS_16 : 16'h0000) ^ x;
    endfunction
    function automatic logic [7:0] g8(input logic [7:0] s, input logic [7:0] x);
        return (s >> 1) ^ (s[0] ? `TAPS_8 : 8'h00) ^ x;
    endfunction
    // B-to-A flow is A-to-B with the sides swapped
    function automatic logic [31:0] sw(input logic [31:0] x, input logic d);
        return d ? {x[15:0], x[31:16]} : x;
    endfunction
    function automatic logic [5:0] mode(input logic [2:0] c);
        return c == 3'h3 ? 6'h10 : c == 3'h7 ? 6'h20 : 6'h02 << c[1:0];
    endfunction
    // One TCK rise on the shift stages
    function automatic logic [31:0] step(input logic [2:0] c, input logic [31:0] x,
        input logic [7:0] p, input logic [7:0] m, input logic d);
        logic [7:0] ai, ao, bi, bo;
        logic [8:0] k;
        {bo, bi, ao, ai} = sw(x, d);
        k = {1'b0, bo} + 9'h001;
        if (c[1:0] == 2'h0)
        begin
            ai = p;
            bo = ~bo;
        end
        else if (c[1:0] != 2'h3)
            {bo, ai} = g16({bo, ai}, {8'h00, c[1] ? p & ~m : 8'h00});
        else
        begin
            ai = g8(ai, p & ~m);
            bo = c[2] ? k[7:0] : g8(bo, 8'h00);
            ao = c[2] ? ao + {7'h00, k[8]} : ao;
        end
        return sw({bo, bi, ao, ai}, d);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Strobe held well past the synchroniser, data held around it
    task automatic pulse(input logic sd);
        repeat (4) @(negedge SYS_CLK);
        if (sd)
            SEED_LOAD <= 1;
        else
            CTRL_UPDATE <= 1;
        repeat (6) @(negedge SYS_CLK);
        SEED_LOAD <= 0;
        CTRL_UPDATE <= 0;
        repeat (6) @(negedge SYS_CLK);
    endtask
    task automatic test_done;
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        SYS_CLK = 0;
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end

    // Whole run needs about 21 us; anything far beyond is a hang
    initial
    begin
        #400000;
        failures++;
        test_done;
    end

    // Every code at least once, both directions at random, zero seed and bypass corners
    initial
    begin
        logic [31:0] s, e;
        logic [7:0] m, pa, pb, ho, hc;
        logic [2:0] c;
        logic d, byp;
        void'($urandom(33));
        repeat (16) @(negedge SYS_CLK);
        SYS_RST <= 0;
        repeat (8) @(negedge SYS_CLK);
        check({CTRL_STATE, MODE_STATE}, {11'h000, 6'h01});
        for (int i = 0; i < 11; i++)
        begin
            c = i == 8 ? 3'h1 : i[2:0];
            byp = i == 10;
            d = i == 8 ? 1'b0 : 1'($urandom);
            m = i == 2 ? 8'hff : 8'($urandom);
            s = $urandom;
            s = i == 8 ? s & 32'h00ffff00 : s;
            pa = $urandom;
            pb = $urandom;
            RUN_TEST_IDLE <= 0;
            A_OE_CELL_N <= !d;
            B_OE_CELL_N <= byp ? !d : d;
            SEED_IN <= s;
            CTRL_IN <= {m, c};
            pulse(1);
            check(MODE_STATE, 6'h01);
            check(CELL_STATE, s);
            pulse(0);
            check(CTRL_STATE, {m, c});
            check({A_PIN_OE, B_PIN_OE}, {d, byp ? d : !d});
            A_PIN_IN <= pa;
            B_PIN_IN <= pb;
            RUN_TEST_IDLE <= 1;
            repeat (8) @(negedge SYS_CLK);
            ho = d ? A_PIN_OUT : B_PIN_OUT;
            hc = d ? CORE_B_IN : CORE_A_IN;
            check(MODE_STATE, byp ? 6'h01 : mode(c));
            go <= 1;
            @(negedge SYS_CLK);
            go <= 0;
            @(negedge SYS_CLK);
            for (int k = 0; busy && k < 99; k++)
                @(negedge SYS_CLK);
            // A burst that never ends is a hang, not a pass
            check({31'h00000000, busy}, 32'h00000000);
            repeat (8) @(negedge SYS_CLK);
            e = s;
            if (!byp)
                repeat (3) e = step(c, e, d ? pb : pa, m, d);
            check(CELL_STATE, e);
            e = sw(e, d);
            check(d ? CORE_B_IN : CORE_A_IN, byp ? hc : e[7:0]);
            check(d ? A_PIN_OUT : B_PIN_OUT, byp || c[1:0] == 2'h2 ? ho : e[31:24]);
        end
        test_done;
    end
endmodule
